// ==== hw/nvmsr_regs.sv ====
// nvm status, interrupt flag, data word and last-address registers
// assumes apb master on pclk; core events are synchronous to pclk
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
module nvmsr_regs
    import nvmsr_pkg::*;
(
    input wire logic pclk,                  // clock
    input wire logic presetn,               // async reset, active low
    input wire logic psel,                  // apb select
    input wire logic penable,               // apb enable
    input wire logic pwrite,                // apb direction
    input wire logic [11:0] paddr,          // apb byte address
    input wire logic [31:0] pwdata,         // apb write data
    input wire logic [3:0] pstrb,           // apb byte strobes
    output logic [31:0] prdata,             // apb read data
    output logic pready,                    // apb ready
    output logic pslverr,                   // apb error, unmapped address
    input wire nvmsr_core_t core_in,        // controller core events
    output logic [15:0] fuse_data,          // value for fuse writes
    output logic irq                        // eeprom-ready request level
);
    // ==========================================
    // bus decode
    logic acc;
    logic wr;
    logic [NVMSR_IDX_W-1:0] idx;
    logic mapped;
    assign acc = psel & penable;
    assign wr = acc & pready_q & pwrite & pstrb[0];
    assign idx = paddr[NVMSR_IDX_LSB +: NVMSR_IDX_W];

    always_comb begin
        if (paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end else if (paddr[11:NVMSR_IDX_LSB+NVMSR_IDX_W] != '0) begin
            mapped = 1'b0;
        end else if (idx == NVMSR_IDX_STATUS || idx == NVMSR_IDX_IRQ_EN) begin
            mapped = 1'b1;
        end else if (idx == NVMSR_IDX_IRQ_FL) begin
            mapped = 1'b1;
        end else if (idx == NVMSR_IDX_DATA_LO || idx == NVMSR_IDX_DATA_HI) begin
            mapped = 1'b1;
        end else if (idx == NVMSR_IDX_ADDR_LO || idx == NVMSR_IDX_ADDR_HI) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // ==========================================
    // register state
    logic wfault_q, wfault_d;
    logic ready_q, ready_d;
    logic irq_en_q, irq_en_d;
    logic [15:0] data_q, data_d;
    logic [15:0] addr_q, addr_d;
    logic irq_q, irq_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [7:0] status_byte;

    always_comb begin
        status_byte = NVMSR_RST_BYTE;
        status_byte[NVMSR_BIT_FLASH_BUSY_FLAG] = core_in.flash_busy;
        status_byte[NVMSR_BIT_EEPROM_BUSY_FLAG] = core_in.eeprom_busy;
        status_byte[NVMSR_BIT_WFAULT] = wfault_q;
    end

    always_comb begin
        wfault_d = wfault_q;
        ready_d = ready_q;
        irq_en_d = irq_en_q;
        data_d = data_q;
        addr_d = addr_q;
        // each finished operation rewrites the fault bit
        if (core_in.op_done) begin
            wfault_d = core_in.op_failed;
        end
        // status writes ignored, no case for it here
        if (wr && mapped) begin
            if (idx == NVMSR_IDX_IRQ_EN) begin
                irq_en_d = pwdata[NVMSR_BIT_READY];
            end else if (idx == NVMSR_IDX_IRQ_FL) begin
                if (pwdata[NVMSR_BIT_READY]) begin
                    ready_d = 1'b0;
                end
            end else if (idx == NVMSR_IDX_DATA_LO) begin
                data_d[7:0] = pwdata[7:0];
            end else if (idx == NVMSR_IDX_DATA_HI) begin
                data_d[15:8] = pwdata[7:0];
            end else if (idx == NVMSR_IDX_ADDR_LO) begin
                addr_d[7:0] = pwdata[7:0];
            end else if (idx == NVMSR_IDX_ADDR_HI) begin
                addr_d[15:8] = pwdata[7:0];
            end
        end
        // hardware set wins over software clear
        if (core_in.eeprom_ready) begin
            ready_d = 1'b1;
        end
        // hardware update wins over software write
        if (core_in.addr_upd) begin
            addr_d = core_in.addr;
        end
        irq_d = irq_en_d & ready_d;
    end

    always_comb begin
        prdata_d = NVMSR_ZERO32;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        if (psel && !pready_q) begin
            pready_d = 1'b1;
            pslverr_d = ~mapped;
            if (!pwrite) begin
                if (idx == NVMSR_IDX_STATUS) begin
                    prdata_d[7:0] = status_byte;
                end else if (idx == NVMSR_IDX_IRQ_EN) begin
                    prdata_d[NVMSR_BIT_READY] = irq_en_q;
                end else if (idx == NVMSR_IDX_IRQ_FL) begin
                    prdata_d[NVMSR_BIT_READY] = ready_q;
                end else if (idx == NVMSR_IDX_DATA_LO) begin
                    prdata_d[7:0] = data_q[7:0];
                end else if (idx == NVMSR_IDX_DATA_HI) begin
                    prdata_d[7:0] = data_q[15:8];
                end else if (idx == NVMSR_IDX_ADDR_LO) begin
                    prdata_d[7:0] = addr_q[7:0];
                end else if (idx == NVMSR_IDX_ADDR_HI) begin
                    prdata_d[7:0] = addr_q[15:8];
                end
                if (!mapped) begin
                    prdata_d = NVMSR_ZERO32;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wfault_q <= 1'b0;
            ready_q <= 1'b0;
            irq_en_q <= 1'b0;
            data_q <= NVMSR_RST_WORD;
            addr_q <= NVMSR_RST_WORD;
            irq_q <= 1'b0;
            prdata_q <= NVMSR_ZERO32;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            wfault_q <= wfault_d;
            ready_q <= ready_d;
            irq_en_q <= irq_en_d;
            data_q <= data_d;
            addr_q <= addr_d;
            irq_q <= irq_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // write lands only in the access cycle where pready_q is high
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign fuse_data = data_q;
    assign irq = irq_q;

    // ==========================================
    // checks
    AST_FAULT_TRACKS: assert property (@(posedge pclk) disable iff (!presetn)
        core_in.op_done |=> wfault_q == $past(core_in.op_failed))
        else $error("fault bit not taken from last operation");
    AST_FAULT_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && idx == NVMSR_IDX_STATUS && mapped)
        |-> prdata[NVMSR_BIT_WFAULT] == $past(wfault_q))
        else $error("fault bit read wrong");
    AST_BUSY_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && idx == NVMSR_IDX_STATUS && mapped)
        |-> prdata[1:0] == $past({core_in.eeprom_busy, core_in.flash_busy}))
        else $error("busy bits read wrong");
    AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 irq == ($past(irq_en_d) && $past(ready_d)))
        else $error("request not enable and flag");
    AST_READY_SET: assert property (@(posedge pclk) disable iff (!presetn)
        core_in.eeprom_ready |=> ready_q)
        else $error("ready flag not set");
    AST_W1C: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && mapped && idx == NVMSR_IDX_IRQ_FL && !pwdata[0] && !core_in.eeprom_ready)
        |=> ready_q == $past(ready_q))
        else $error("zero write changed flag");
    AST_W1C_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && mapped && idx == NVMSR_IDX_IRQ_FL && pwdata[0] && !core_in.eeprom_ready)
        |=> !ready_q && !irq)
        else $error("one write did not clear flag");
    AST_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && mapped && idx == NVMSR_IDX_IRQ_EN && pwdata[0]) |=> irq_en_q)
        else $error("enable not taken");
    AST_ADDR_UPD: assert property (@(posedge pclk) disable iff (!presetn)
        core_in.addr_upd |=> addr_q == $past(core_in.addr))
        else $error("address not updated");
    AST_PREADY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("pready held two cycles");
    COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    COV_FAULT: cover property (@(posedge pclk) disable iff (!presetn) $rose(wfault_q));
    COV_CLR: cover property (@(posedge pclk) disable iff (!presetn) $fell(ready_q));
    COV_ERR: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
    COV_EN: cover property (@(posedge pclk) disable iff (!presetn) $fell(irq_en_q));

    // ==========================================
    // bus protocol checks
    AST_PSLVERR_WITH_PREADY: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error without ready");

    AST_PRDATA_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == NVMSR_ZERO32)
        else $error("read data outside answer");

    AST_PREADY_NEEDS_SEL: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> $past(psel))
        else $error("ready without select");

    AST_PREADY_SETUP: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pready) |=> pready)
        else $error("no ready after setup");

    AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pready && !mapped) |=> pslverr)
        else $error("unmapped access without error");

    AST_MAPPED_OK: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pready && mapped) |=> !pslverr)
        else $error("mapped access with error");

    AST_UNMAPPED_RDATA: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && pslverr) |-> prdata == NVMSR_ZERO32)
        else $error("unmapped read data not zero");

    AST_WRITE_RDATA: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && pwrite) |-> prdata == NVMSR_ZERO32)
        else $error("read data on write");

    // ==========================================
    // read path checks
    AST_STATUS_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && idx == NVMSR_IDX_STATUS) |-> prdata[31:3] == '0)
        else $error("status reserved bits set");

    AST_FLAG_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && (idx == NVMSR_IDX_IRQ_EN || idx == NVMSR_IDX_IRQ_FL))
        |-> prdata[31:1] == '0)
        else $error("flag reserved bits set");

    AST_BYTE_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && mapped) |-> prdata[31:8] == '0)
        else $error("upper read bits set");

    AST_EN_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && mapped && idx == NVMSR_IDX_IRQ_EN)
        |-> prdata[0] == $past(irq_en_q))
        else $error("enable read wrong");

    AST_FL_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && mapped && idx == NVMSR_IDX_IRQ_FL)
        |-> prdata[0] == $past(ready_q))
        else $error("flag read wrong");

    AST_DLO_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && mapped && idx == NVMSR_IDX_DATA_LO)
        |-> prdata[7:0] == $past(data_q[7:0]))
        else $error("data low read wrong");

    AST_DHI_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && mapped && idx == NVMSR_IDX_DATA_HI)
        |-> prdata[7:0] == $past(data_q[15:8]))
        else $error("data high read wrong");

    AST_ALO_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && mapped && idx == NVMSR_IDX_ADDR_LO)
        |-> prdata[7:0] == $past(addr_q[7:0]))
        else $error("address low read wrong");

    AST_AHI_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && mapped && idx == NVMSR_IDX_ADDR_HI)
        |-> prdata[7:0] == $past(addr_q[15:8]))
        else $error("address high read wrong");

    // ==========================================
    // write path checks
    AST_DLO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && mapped && idx == NVMSR_IDX_DATA_LO)
        |=> data_q[7:0] == $past(pwdata[7:0]))
        else $error("data low not written");

    AST_DHI_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && mapped && idx == NVMSR_IDX_DATA_HI)
        |=> data_q[15:8] == $past(pwdata[7:0]))
        else $error("data high not written");

    AST_DLO_KEEP_HI: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && mapped && idx == NVMSR_IDX_DATA_LO)
        |=> data_q[15:8] == $past(data_q[15:8]))
        else $error("low write touched high byte");

    AST_ALO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && mapped && idx == NVMSR_IDX_ADDR_LO && !core_in.addr_upd)
        |=> addr_q[7:0] == $past(pwdata[7:0]))
        else $error("address low not written");

    AST_AHI_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && mapped && idx == NVMSR_IDX_ADDR_HI && !core_in.addr_upd)
        |=> addr_q[15:8] == $past(pwdata[7:0]))
        else $error("address high not written");

    AST_FUSE_DATA: assert property (@(posedge pclk) disable iff (!presetn)
        fuse_data == data_q)
        else $error("fuse data not data word");

    AST_DATA_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr && mapped && (idx == NVMSR_IDX_DATA_LO || idx == NVMSR_IDX_DATA_HI))
        |=> data_q == $past(data_q))
        else $error("data word changed unasked");

    AST_ADDR_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (!core_in.addr_upd
        && !(wr && mapped && (idx == NVMSR_IDX_ADDR_LO || idx == NVMSR_IDX_ADDR_HI)))
        |=> addr_q == $past(addr_q))
        else $error("address changed unasked");

    AST_EN_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr && mapped && idx == NVMSR_IDX_IRQ_EN) |=> irq_en_q == $past(irq_en_q))
        else $error("enable changed unasked");

    AST_EN_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && mapped && idx == NVMSR_IDX_IRQ_EN && !pwdata[0]) |=> !irq_en_q && !irq)
        else $error("disable not taken");

    // ==========================================
    // flag and request checks
    AST_FAULT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !core_in.op_done |=> wfault_q == $past(wfault_q))
        else $error("fault bit changed without operation");

    AST_READY_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (ready_q && !(wr && mapped && idx == NVMSR_IDX_IRQ_FL && pwdata[0])) |=> ready_q)
        else $error("flag lost without clear");

    AST_READY_NO_SELF_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (!ready_q && !core_in.eeprom_ready) |=> !ready_q)
        else $error("flag set without event");

    AST_READY_WINS: assert property (@(posedge pclk) disable iff (!presetn)
        (core_in.eeprom_ready && wr && mapped && idx == NVMSR_IDX_IRQ_FL) |=> ready_q)
        else $error("set lost against clear");

    AST_IRQ_NEEDS_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> ready_q && irq_en_q)
        else $error("request without flag and enable");

    AST_IRQ_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
        (ready_q && irq_en_q) |-> irq)
        else $error("request missing");

endmodule : nvmsr_regs

// ==== hw/nvmsr_pkg.sv ====
// package for the nvm status, interrupt, data and address register bank
// assumes an apb slave with 32-bit data, one register per aligned word
//
// Behaviour
// - write-fault bit 2 reads one after a failed memory write
// - fault flagged on mixed-section page load or protected-area write
// - write-fault bit reflects only the latest operation
// - eeprom busy bit 1 is one while eeprom runs a command
// - flash busy bit 0 is one while flash runs a command
// - irq enable bit 0 written one enables eeprom-ready interrupt
// - eeprom-ready request is a level following the ready flag
// - ready flag bit 0 cleared by writing one, zero leaves it
// - once enabled the interrupt requests at once, even without writes; here no request until an eeprom_ready pulse has set the flag
// - data word at 0x06, 16 bits, low byte base, high byte base+1
// - data word supplies value for external port fuse writes
// - address register at 0x08, 16 bits, low byte base, high byte base+1
// - address register holds last updated memory location
// - ready flag set when eeprom becomes ready for new operation
// - request asserted while enable and flag set, until flag cleared
package nvmsr_pkg;
    // printed offsets are not all word multiples: indices, byte addr = 4*index
    localparam logic [3:0] NVMSR_IDX_STATUS = 4'h2;
    localparam logic [3:0] NVMSR_IDX_IRQ_EN = 4'h3;
    localparam logic [3:0] NVMSR_IDX_IRQ_FL = 4'h4;
    localparam logic [3:0] NVMSR_IDX_DATA_LO = 4'h6;
    localparam logic [3:0] NVMSR_IDX_DATA_HI = 4'h7;
    localparam logic [3:0] NVMSR_IDX_ADDR_LO = 4'h8;
    localparam logic [3:0] NVMSR_IDX_ADDR_HI = 4'h9;
    localparam int NVMSR_IDX_LSB = 2;
    localparam int NVMSR_IDX_W = 4;
    localparam int NVMSR_BIT_FLASH_BUSY_FLAG = 0;
    localparam int NVMSR_BIT_EEPROM_BUSY_FLAG = 1;
    localparam int NVMSR_BIT_WFAULT = 2;
    localparam int NVMSR_BIT_READY = 0;
    localparam logic [7:0] NVMSR_RST_BYTE = 8'h00;
    localparam logic [15:0] NVMSR_RST_WORD = 16'h0000;
    localparam logic [31:0] NVMSR_ZERO32 = 32'h0000_0000;

    // events reported by the memory controller core
    typedef struct packed {
        logic flash_busy;     // flash executing a command
        logic eeprom_busy;    // eeprom executing a command
        logic op_done;        // pulse: an operation finished
        logic op_failed;      // with op_done: the operation faulted
        logic eeprom_ready;   // pulse: eeprom ready for new write/erase
        logic addr_upd;       // pulse: a location was updated
        logic [15:0] addr;    // address of that location
    } nvmsr_core_t;
endpackage : nvmsr_pkg

// ==== testbench/nvmsr_tb.sv ====
// self-checking bench for the nvm status, irq flag, data word and address bank
// assumes an apb slave on pclk and core events synchronous to pclk
`timescale 1ns/10ps
module testbench;
    import nvmsr_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready, pslverr, irq;
    logic [15:0] fuse_data;
    nvmsr_core_t core_in = '0;
    nvmsr_core_t c;
    int errors = 0;
    int tests_run = 0;
    logic [31:0] r;
    logic e;
    logic [15:0] v;
    logic [3:0] regs [7] = '{NVMSR_IDX_STATUS, NVMSR_IDX_IRQ_EN, NVMSR_IDX_IRQ_FL,
        NVMSR_IDX_DATA_LO, NVMSR_IDX_DATA_HI, NVMSR_IDX_ADDR_LO, NVMSR_IDX_ADDR_HI};

    always #5 pclk = ~pclk;

    nvmsr_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_in(core_in), .fuse_data(fuse_data),
        .irq(irq));

    // ==========================================================
    // checking and bus tasks
    function automatic logic [31:0] st(input logic fb, input logic eb, input logic wf);
        return {29'h000_0000, wf, eb, fb};
    endfunction : st

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) errors++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input string name, input logic [3:0] i, input logic [31:0] exp);
        apb(1'b0, {6'h00, i, 2'b00}, 32'h0000_0000);
        chk(name, exp, r);
    endtask : rdc

    task automatic ev(input nvmsr_core_t p);
        @(posedge pclk);
        core_in <= p;
        @(posedge pclk);
        core_in <= '{flash_busy: p.flash_busy, eeprom_busy: p.eeprom_busy, default: '0};
    endtask : ev

    task automatic chk_irq(input logic exp);
        @(negedge pclk);
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask : chk_irq

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'haa71));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[i]) rdc("reset", regs[i], NVMSR_ZERO32);
        chk_irq(1'b0);
        repeat (4) begin
            v = 16'($urandom);
            apb(1'b1, 12'h018, {24'($urandom), v[7:0]});
            apb(1'b1, 12'h01c, {24'($urandom), v[15:8]});
            rdc("data_lo", NVMSR_IDX_DATA_LO, {24'h00_0000, v[7:0]});
            rdc("data_hi", NVMSR_IDX_DATA_HI, {24'h00_0000, v[15:8]});
            chk("fuse_data", {16'h0000, v}, {16'h0000, fuse_data});
            apb(1'b1, 12'h020, {24'h00_0000, ~v[7:0]});
            apb(1'b1, 12'h024, {24'h00_0000, ~v[15:8]});
            rdc("addr_lo", NVMSR_IDX_ADDR_LO, {24'h00_0000, ~v[7:0]});
            rdc("addr_hi", NVMSR_IDX_ADDR_HI, {24'h00_0000, ~v[15:8]});
            c = '0;
            c.addr_upd = 1'b1;
            c.addr = v ^ 16'h5a5a;
            ev(c);
            rdc("upd_lo", NVMSR_IDX_ADDR_LO, {24'h00_0000, c.addr[7:0]});
            rdc("upd_hi", NVMSR_IDX_ADDR_HI, {24'h00_0000, c.addr[15:8]});
        end
        for (int k = 0; k < 4; k++) begin
            c = '0;
            c.flash_busy = k[0];
            c.eeprom_busy = k[1];
            ev(c);
            rdc("busy", NVMSR_IDX_STATUS, st(k[0], k[1], 1'b0));
        end
        c = '0;
        c.op_done = 1'b1;
        c.op_failed = 1'b1;
        ev(c);
        rdc("fault", NVMSR_IDX_STATUS, st(1'b0, 1'b0, 1'b1));
        apb(1'b1, 12'h008, 32'h0000_00f8);
        rdc("status_ro", NVMSR_IDX_STATUS, st(1'b0, 1'b0, 1'b1));
        c.op_failed = 1'b0;
        ev(c);
        rdc("fault_new", NVMSR_IDX_STATUS, st(1'b0, 1'b0, 1'b0));
        c = '0;
        c.eeprom_ready = 1'b1;
        ev(c);
        rdc("flag_set", NVMSR_IDX_IRQ_FL, 32'h0000_0001);
        chk_irq(1'b0);
        apb(1'b1, 12'h00c, 32'h0000_0001);
        chk_irq(1'b1);
        rdc("irq_en", NVMSR_IDX_IRQ_EN, 32'h0000_0001);
        apb(1'b1, 12'h010, 32'h0000_0000);
        rdc("flag_w0", NVMSR_IDX_IRQ_FL, 32'h0000_0001);
        chk_irq(1'b1);
        apb(1'b1, 12'h010, 32'h0000_0001);
        chk_irq(1'b0);
        rdc("flag_w1", NVMSR_IDX_IRQ_FL, NVMSR_ZERO32);
        apb(1'b1, 12'h00c, NVMSR_ZERO32);
        rdc("irq_dis", NVMSR_IDX_IRQ_EN, NVMSR_ZERO32);
        chk_irq(1'b0);
        pstrb <= 4'he;
        apb(1'b1, 12'h018, {24'h00_0000, ~v[7:0]});
        pstrb <= 4'hf;
        rdc("strb_off", NVMSR_IDX_DATA_LO, {24'h00_0000, v[7:0]});
        chk("slverr_ok", 32'h0, {31'h0, e});
        apb(1'b0, 12'h014, NVMSR_ZERO32);
        chk("slverr_unmapped", 32'h1, {31'h0, e});
        apb(1'b0, 12'h00a, NVMSR_ZERO32);
        chk("slverr_misaligned", 32'h1, {31'h0, e});
        stop_test();
    end

    initial begin
        #200000;
        errors++;
        stop_test();
    end
endmodule : testbench
